// ---- src/timer_io_top.sv ----
// 16-bit timer with capture cache and two digital inputs and outputs, on an ahb-lite slave
// Summary of operation
// - status bit 0 is set on a timer event, zero otherwise.
// - non-zero task select clears the event flag automatically.
// - task select zero: reading status clears the event flag.
// - status bit 1 is set on every wrap, in all modes.
// - reading status clears the wrap flag.
// - count is readable and writable at any time, effective immediately.
// - writable 16-bit limit; the counter wraps when it reaches it.
// - capture modes store the latched count in the capture cache.
// - each wrap raises an interrupt; tiny limits can flood software.
// - input state bits read 0 for low, 1 for high.
// - output bit 0 drives low, 1 drives high.
// - combined output register aliases the two single output bits.
// - mode 0 events on wrap; modes 1/2 capture on rising/falling edge.
// - task select 0 schedules nothing, 1 to 4 one of four tasks.
// - clock source internal or input 1; prescale 1, 4, 16, 64.
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`default_nettype none
`include "timer_io_map.svh"
module timer_io_top
    import timer_io_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        clk_en,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        capture_input_pin,
    input  wire logic        external_count_clock_pin,
    output logic [1:0]       digital_out,
    output logic [3:0]       event_task_strobe,
    output logic             irq
);
    typedef struct packed {
        bus_state_t          bus;
        logic [11:0]         addr;
        logic [`CTL_WIDTH-1:0] ctl;
        logic                timer_event_flag;
        logic                wrap_flag;
        logic [15:0]         count;
        logic [15:0]         limit;
        logic [15:0]         capture;
        logic [1:0]          outs;
        logic [1:0]          in_sync1;
        logic [1:0]          in_sync2;
        logic                cap_prev;
        logic [`IRQ_WIDTH-1:0] irq_stat;
        logic [`IRQ_WIDTH-1:0] irq_en;
        logic [3:0]          task_strobe;
        logic [31:0]         rdata;
    } top_state_t;

    top_state_t  s_q;
    top_state_t  s_d;
    logic        tick;
    logic        wrap;
    logic        cap_edge;
    logic        take_cycle;
    logic [31:0] wdata;
    timer_mode_t mode;
    logic [2:0]  task_sel;

    // bus decode for the read mux; the read side effects compare haddr on their own
    function automatic logic [31:0] read_value(input top_state_t s, input logic [11:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            `OFF_CONTROL:    v[`CTL_WIDTH-1:0] = s.ctl;
            `OFF_STATUS:     v[1:0] = {s.wrap_flag, s.timer_event_flag};
            `OFF_COUNT:      v[15:0] = s.count;
            `OFF_LIMIT:      v[15:0] = s.limit;
            `OFF_CAPTURE:    v[15:0] = s.capture;
            `OFF_IN0:        v[0] = s.in_sync2[0];
            `OFF_IN1:        v[0] = s.in_sync2[1];
            `OFF_OUT0:       v[0] = s.outs[0];
            `OFF_OUT1:       v[0] = s.outs[1];
            `OFF_OUTS:       v[1:0] = s.outs;
            `OFF_IRQ_STATUS: v[`IRQ_WIDTH-1:0] = s.irq_stat;
            `OFF_IRQ_ENABLE: v[`IRQ_WIDTH-1:0] = s.irq_en;
            default:         v = 32'h0000_0000;
        endcase
        return v;
    endfunction : read_value

    count_tick_gen u_tick (
        .hclk                     (hclk),
        .hresetn                  (hresetn),
        .clk_en                   (clk_en),
        .run                      (s_q.ctl[`CTL_EN_BIT]),
        .use_external             (s_q.ctl[`CTL_CS_BIT]),
        .prescale_sel             (s_q.ctl[`CTL_PRE_MSB:`CTL_PRE_LSB]),
        .external_count_clock_pin (external_count_clock_pin),
        .tick                     (tick)
    );

    always_comb begin
        case (s_q.ctl[`CTL_MODE_MSB:`CTL_MODE_LSB])
            2'h1: mode = MODE_CAP_R;
            2'h2: mode = MODE_CAP_F;
            default: mode = MODE_FREE;
        endcase
    end

    assign task_sel   = s_q.ctl[`CTL_TASK_MSB:`CTL_TASK_LSB];
    assign take_cycle = hsel && hready && htrans[1];
    assign wdata      = hwdata;
    // wrap when count equals limit on a tick
    assign wrap       = tick && (s_q.count == s_q.limit);

    // capture edge select on synchronised input 0
    always_comb begin
        case (mode)
            MODE_CAP_R: cap_edge = s_q.in_sync2[0] && !s_q.cap_prev;
            MODE_CAP_F: cap_edge = !s_q.in_sync2[0] && s_q.cap_prev;
            default:    cap_edge = 1'b0;
        endcase
    end

    always_comb begin
        logic event_now;
        logic [3:0] strobe;
        s_d = s_q;
        event_now = 1'b0;
        strobe = 4'h0;
        s_d.in_sync1 = {external_count_clock_pin, capture_input_pin};
        s_d.in_sync2 = s_q.in_sync1;
        s_d.cap_prev = s_q.in_sync2[0];
        s_d.rdata = 32'h0000_0000;

        // address phase captured; wait states only while clk_en is low
        if (take_cycle) begin
            s_d.bus  = hwrite ? BUS_WRITE : BUS_READ;
            s_d.addr = haddr;
            if (!hwrite) begin
                s_d.rdata = read_value(s_q, haddr);
            end
        end else if (hready) begin
            s_d.bus = BUS_IDLE;
        end

        // clear on status read, before any new event
        if (take_cycle && !hwrite && haddr == `OFF_STATUS) begin
            s_d.wrap_flag = 1'b0;
            if (task_sel == 3'h0) begin
                s_d.timer_event_flag = 1'b0;
            end
        end

        // counter advance; a software write below overrides it
        if (tick) begin
            s_d.count = wrap ? `COUNT_RESET : s_q.count + 16'h0001;
        end

        if (cap_edge && s_q.ctl[`CTL_EN_BIT]) begin
            s_d.capture = s_q.count;
            event_now = 1'b1;
        end
        // free running mode events on wrap
        if (wrap && mode == MODE_FREE) begin
            event_now = 1'b1;
        end

        if (s_q.timer_event_flag && task_sel != 3'h0) begin
            s_d.timer_event_flag = 1'b0;
            if (task_sel <= 3'h4) begin
                strobe[task_sel[1:0] - 2'h1] = 1'b1;
            end
        end
        s_d.task_strobe = strobe;

        // data phase of a write
        if (s_q.bus == BUS_WRITE) begin
            case (s_q.addr)
                `OFF_CONTROL: s_d.ctl = wdata[`CTL_WIDTH-1:0];
                `OFF_COUNT:   s_d.count = wdata[15:0];
                `OFF_LIMIT:   s_d.limit = wdata[15:0];
                `OFF_CAPTURE: s_d.capture = wdata[15:0];
                // single and combined views share one register
                `OFF_OUT0:    s_d.outs[0] = wdata[0];
                `OFF_OUT1:    s_d.outs[1] = wdata[0];
                `OFF_OUTS:    s_d.outs = wdata[1:0];
                `OFF_IRQ_ENABLE: s_d.irq_en = wdata[`IRQ_WIDTH-1:0];
                `OFF_IRQ_CLEAR:  s_d.irq_stat = s_q.irq_stat & ~wdata[`IRQ_WIDTH-1:0];
                default: ;
            endcase
        end

        if (event_now) begin
            s_d.timer_event_flag = 1'b1;
        end
        if (wrap) begin
            s_d.wrap_flag = 1'b1;
        end
        s_d.irq_stat[`IRQ_WRAP_BIT]  = s_d.irq_stat[`IRQ_WRAP_BIT] | wrap;
        s_d.irq_stat[`IRQ_EVENT_BIT] = s_d.irq_stat[`IRQ_EVENT_BIT] | event_now;
        s_d.irq_stat[`IRQ_TASK_MSB:`IRQ_TASK_LSB] = s_d.irq_stat[`IRQ_TASK_MSB:`IRQ_TASK_LSB] | strobe;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.bus <= BUS_IDLE;
            s_q.ctl <= `CTL_RESET;
            s_q.count <= `COUNT_RESET;
            s_q.limit <= `LIMIT_RESET;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // clock enable low stalls the bus rather than losing a transfer
    assign hreadyout         = clk_en;
    assign hresp             = 1'b0;
    assign hrdata            = s_q.rdata;
    assign digital_out       = s_q.outs;
    assign event_task_strobe = s_q.task_strobe;
    assign irq               = |(s_q.irq_stat & s_q.irq_en);
endmodule : timer_io_top
`default_nettype wire

// ---- src/timer_io_map.svh ----
// register offsets, field positions and constants for the timer and digital i/o block
`ifndef TIMER_IO_MAP_SVH
`define TIMER_IO_MAP_SVH

`define OFF_CONTROL      12'h000
`define OFF_STATUS       12'h004
`define OFF_COUNT        12'h008
`define OFF_LIMIT        12'h00C
`define OFF_CAPTURE      12'h010
`define OFF_IN0          12'h014
`define OFF_IN1          12'h018
`define OFF_OUT0         12'h01C
`define OFF_OUT1         12'h020
`define OFF_OUTS         12'h024
`define OFF_IRQ_STATUS   12'h028
`define OFF_IRQ_ENABLE   12'h02C
`define OFF_IRQ_CLEAR    12'h030

`define CTL_TASK_LSB     0
`define CTL_TASK_MSB     2
`define CTL_EN_BIT       3
`define CTL_CS_BIT       4
`define CTL_PRE_LSB      5
`define CTL_PRE_MSB      6
`define CTL_MODE_LSB     7
`define CTL_MODE_MSB     8
`define CTL_WIDTH        9
`define CTL_RESET        9'h000

`define ST_EVENT_BIT     0
`define ST_WRAP_BIT      1

`define IRQ_WRAP_BIT     0
`define IRQ_EVENT_BIT    1
`define IRQ_TASK_LSB     2
`define IRQ_TASK_MSB     5
`define IRQ_WIDTH        6

`define PRE_DIV1         8'h00
`define PRE_DIV4         8'h03
`define PRE_DIV16        8'h0F
`define PRE_DIV64        8'h3F

`define TASK_COUNT       4
`define COUNT_RESET      16'h0000
`define LIMIT_RESET      16'hFFFF

`endif

// ---- src/timer_io_pkg.sv ----
// types shared by the timer and digital i/o block
`default_nettype none
package timer_io_pkg;
    typedef enum logic [2:0] {
        MODE_FREE    = 3'b001,
        MODE_CAP_R   = 3'b010,
        MODE_CAP_F   = 3'b100
    } timer_mode_t;

    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ  = 3'b100
    } bus_state_t;
endpackage : timer_io_pkg
`default_nettype wire

// ---- src/count_tick_gen.sv ----
// count tick source: internal prescaler or rising edge of the external count pin
`default_nettype none
`include "timer_io_map.svh"
module count_tick_gen
    import timer_io_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       clk_en,
    input  wire logic       run,
    input  wire logic       use_external,
    input  wire logic [1:0] prescale_sel,
    input  wire logic       external_count_clock_pin,
    output logic            tick
);
    typedef struct packed {
        logic [7:0] div;
        logic       ext_sync1;
        logic       ext_sync2;
        logic       ext_prev;
    } tick_state_t;

    tick_state_t s_q;
    tick_state_t s_d;
    logic [7:0]  div_end;

    always_comb begin
        case (prescale_sel)
            2'h0: div_end = `PRE_DIV1;
            2'h1: div_end = `PRE_DIV4;
            2'h2: div_end = `PRE_DIV16;
            default: div_end = `PRE_DIV64;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.ext_sync1 = external_count_clock_pin;
        s_d.ext_sync2 = s_q.ext_sync1;
        s_d.ext_prev  = s_q.ext_sync2;
        tick = 1'b0;
        if (!run) begin
            s_d.div = 8'h00;
        end else if (use_external) begin
            tick = s_q.ext_sync2 && !s_q.ext_prev;
        end else if (s_q.div >= div_end) begin
            s_d.div = 8'h00;
            tick = 1'b1;
        end else begin
            s_d.div = s_q.div + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end
endmodule : count_tick_gen
`default_nettype wire

// ---- sim/timer_io_chk.sv ----
// assertion checker for the timer and digital i/o block
`default_nettype none
`include "timer_io_map.svh"
module timer_io_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        clk_en,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  digital_out,
    input wire logic [3:0]  event_task_strobe,
    input wire logic        irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic        tk_q;
    logic        wr_q;
    logic [11:0] a_q;
    logic        wd;
    // data phase of a taken transfer, so writes can be tied to their effect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tk_q <= 1'b0;
            wr_q <= 1'b0;
            a_q  <= 12'h000;
        // a data phase stalled by clk_en low keeps its transfer, as the design holds hrdata
        end else if (clk_en) begin
            tk_q <= hsel & hready & htrans[1] & clk_en;
            wr_q <= hwrite;
            a_q  <= haddr;
        end
    end
    assign wd = tk_q & wr_q & clk_en;
    chk_ready_en: assert property (hreadyout == clk_en) else $error("hreadyout not clk_en");
    chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    chk_rdata_idle: assert property (!(tk_q && !wr_q) |-> hrdata == 32'h0) else $error("hrdata not zero");
    chk_strobe_one: assert property ($onehot0(event_task_strobe)) else $error("two task strobes");
    chk_out_zero: assert property (wd && a_q == `OFF_OUT0 |=> digital_out[0] == $past(hwdata[0]))
        else $error("output 0 wrong");
    chk_out_one: assert property (wd && a_q == `OFF_OUT1 |=> digital_out[1] == $past(hwdata[0]))
        else $error("output 1 wrong");
    chk_outs_both: assert property (wd && a_q == `OFF_OUTS |=> digital_out == $past(hwdata[1:0]))
        else $error("outputs wrong");
    chk_irq_mask: assert property (wd && a_q == `OFF_IRQ_ENABLE && hwdata[5:0] == 6'h00 |=> !irq)
        else $error("irq not masked");
endmodule : timer_io_chk
bind timer_io_top timer_io_chk u_chk (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .digital_out(digital_out), .event_task_strobe(event_task_strobe),
    .irq(irq));
`default_nettype wire

// ---- sim/io_line_model.sv ----
// far-side digital lines: capture input level and a gated count clock
`default_nettype none
module io_line_model #(
    parameter int HALF = 8
) (
    input  wire logic hclk,
    input  wire logic cap_level,
    input  wire logic clk_run,
    output logic      capture_input_pin,
    output logic      external_count_clock_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    // the count clock stands low outside a burst, as a real encoder line idles
    always @(posedge hclk) begin
        capture_input_pin <= cap_level;
        n <= clk_run ? (n + 1) % HALF : 0;
        if (!clk_run)
            external_count_clock_pin <= 1'b0;
        else if (n == HALF - 1)
            external_count_clock_pin <= !external_count_clock_pin;
    end
endmodule : io_line_model
`default_nettype wire

// ---- sim/timer_capture_and_digital_io_tb.sv ----
// self-checking bench for the timer and digital i/o block
`default_nettype none
`include "timer_io_map.svh"
module timer_capture_and_digital_io_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0, dout;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, irq, cap = 1'b0, run = 1'b0, cin, xin;
    logic [3:0]  stb, s;
    int          errors = 0, samples_checked = 0;

    timer_io_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .capture_input_pin(cin), .external_count_clock_pin(xin),
        .digital_out(dout), .event_task_strobe(stb), .irq(irq));
    io_line_model #(.HALF(8)) u_lines (.hclk(hclk), .cap_level(cap), .clk_run(run),
        .capture_input_pin(cin), .external_count_clock_pin(xin));

    initial begin
        forever #20 hclk = ~hclk;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one single ahb-lite transfer; read data is taken at the data phase end edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer

    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        check(nm, rd, e);
    endtask : rchk

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (6000) @(posedge hclk);
        errors++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk("control", `OFF_CONTROL, 32'h0);
        rchk("status", `OFF_STATUS, 32'h0);
        rchk("limit", `OFF_LIMIT, 32'hFFFF);
        xfer(1'b1, 12'h100, 32'h5A5A);
        rchk("unmapped", 12'h100, 32'h0);
        xfer(1'b1, `OFF_COUNT, 32'h1234);
        rchk("count", `OFF_COUNT, 32'h1234);
        $display("test access done");
        // divide by 64 leaves time to see the zero right after the wrap
        xfer(1'b1, `OFF_LIMIT, 32'h7);
        xfer(1'b1, `OFF_COUNT, 32'h7);
        xfer(1'b1, `OFF_IRQ_ENABLE, 32'h1);
        xfer(1'b1, `OFF_CONTROL, 32'h068);
        do xfer(1'b0, `OFF_COUNT, 32'h0); while (rd === 32'h7);
        check("wrap count", rd, 32'h0);
        check("irq", 32'(irq), 32'h1);
        rchk("status wrap", `OFF_STATUS, 32'h3);
        rchk("status read", `OFF_STATUS, 32'h0);
        xfer(1'b1, `OFF_IRQ_ENABLE, 32'h0);
        @(posedge hclk);
        check("masked", 32'(irq), 32'h0);
        xfer(1'b1, `OFF_IRQ_CLEAR, 32'h1);
        xfer(1'b1, `OFF_IRQ_ENABLE, 32'h1);
        @(posedge hclk);
        check("cleared", 32'(irq), 32'h0);
        $display("test wrap done");
        xfer(1'b1, `OFF_LIMIT, 32'h1);
        for (int t = 1; t <= 4; t++) begin
            xfer(1'b1, `OFF_COUNT, 32'h0);
            xfer(1'b1, `OFF_CONTROL, 32'h8 | t);
            s = 4'h0;
            for (int k = 0; k < 20 && s == 4'h0; k++) begin
                @(posedge hclk);
                s = stb;
            end
            check("strobe", 32'(s), 32'h1 << (t - 1));
            // stop with the task kept: a wrap on the stopping edge is still auto-cleared a cycle later
            xfer(1'b1, `OFF_CONTROL, 32'(t));
            @(posedge hclk);
            rchk("auto clear", `OFF_STATUS, 32'h2);
        end
        $display("test tasks done");
        xfer(1'b1, `OFF_COUNT, 32'h1234);
        xfer(1'b1, `OFF_CONTROL, 32'h098);
        cap <= 1'b1;
        repeat (8) @(posedge hclk);
        rchk("in0 high", `OFF_IN0, 32'h1);
        rchk("capture rise", `OFF_CAPTURE, 32'h1234);
        rchk("event", `OFF_STATUS, 32'h1);
        xfer(1'b1, `OFF_COUNT, 32'h2222);
        cap <= 1'b0;
        repeat (8) @(posedge hclk);
        rchk("in0 low", `OFF_IN0, 32'h0);
        rchk("capture hold", `OFF_CAPTURE, 32'h1234);
        xfer(1'b1, `OFF_CONTROL, 32'h118);
        cap <= 1'b1;
        repeat (8) @(posedge hclk);
        cap <= 1'b0;
        repeat (8) @(posedge hclk);
        rchk("capture fall", `OFF_CAPTURE, 32'h2222);
        $display("test capture done");
        xfer(1'b1, `OFF_CONTROL, 32'h078);
        run <= 1'b1;
        repeat (48) @(posedge hclk);
        run <= 1'b0;
        repeat (6) @(posedge hclk);
        rchk("ext count", `OFF_COUNT, 32'h2225);
        rchk("in1", `OFF_IN1, 32'h0);
        $display("test external clock done");
        xfer(1'b1, `OFF_OUT0, 32'h1);
        rchk("outs", `OFF_OUTS, 32'h1);
        xfer(1'b1, `OFF_OUTS, 32'h2);
        rchk("out1", `OFF_OUT1, 32'h1);
        check("pins", 32'(dout), 32'h2);
        xfer(1'b1, `OFF_OUT1, 32'h0);
        rchk("out0", `OFF_OUT0, 32'h0);
        clk_en <= 1'b0;
        repeat (3) @(posedge hclk);
        clk_en <= 1'b1;
        $display("test outputs done");
        complete_run();
    end
endmodule : timer_capture_and_digital_io_tb
`default_nettype wire
